/* pdc_defines.svh */
// Register offsets, field positions, reset values and field codes for the PLL divider path
`ifndef PDC_DEFINES_SVH
`define PDC_DEFINES_SVH
`define PDC_OFF_SRC       12'h000
`define PDC_OFF_RDIV      12'h004
`define PDC_OFF_LDIV      12'h008
`define PDC_OFF_POST      12'h00c
`define PDC_OFF_MODE      12'h010
`define PDC_OFF_STATUS    12'h014
`define PDC_SRC_RDIV_BIT  0
`define PDC_SRC_LOOP_BIT  1
`define PDC_SRC_PDL_BIT   2
`define PDC_SRC_PDR_BIT   3
`define PDC_MODE_FILT_BIT 0
`define PDC_MODE_FINE_BIT 1
`define PDC_MODE_DETO_BIT 2
`define PDC_MODE_RNG_BIT  3
`define PDC_MODE_KIND_BIT 4
`define PDC_MODE_XR_LSB   5
`define PDC_MODE_PUMP_LSB 8
`define PDC_XTAL_OFF_CODE 3'h7
`define PDC_PUMP_32UA     2'h3
`define PDC_RST_SRC       4'h2
`define PDC_RST_RDIV      12'h000
`define PDC_RST_LDIV      15'h0001
`define PDC_RST_POST      6'h00
`define PDC_RST_MODE      10'h000
`endif

/* pdc_pkg.sv */
// Types shared by the PLL divider path
package pdc_pkg;
  typedef logic [1:0] pdc_post_code_type;
  typedef logic [2:0] pdc_post_mod_type;
endpackage

/* pdc_divider.sv */
// Modulus-N clock-enable divider that reloads its modulus only at terminal count
`timescale 1ns/1ps
`default_nettype none
module pdc_divider #(
  parameter int WIDTH = 12
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             tick_in,
  input  wire logic [WIDTH-1:0] modulus,
  output logic                  tick_out
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] active_reg;

  if (WIDTH < 1 || WIDTH > 16) begin : g_width_check
    $error("pdc_divider: WIDTH out of range");
  end

  // Modulus field value m divides by m+1; new value taken only at wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg  <= '0;
      active_reg <= '0;
    end else if (tick_in) begin
      if (count_reg >= active_reg) begin
        count_reg  <= '0;
        active_reg <= modulus;
      end else begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  assign tick_out = tick_in && (count_reg >= active_reg);
endmodule
`default_nettype wire

/* pdc_path.sv */
// PLL divider and source-selection path with APB configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defines.svh"
module pdc_path
  import pdc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        xtal_tick,
  input  wire logic        ref_pin,
  input  wire logic        vco_tick,
  input  wire logic        return_clock_pin,
  output logic             pd_lhs_out,
  output logic             pd_rhs_out,
  output logic             clk_out_tick,
  output logic             outboard_filter_sel,
  output logic             xtal_fine_tune_en,
  output logic             xtal_detector_off,
  output logic             osc_range_sel,
  output logic [2:0]       xtal_ratio_code,
  output logic             oscillator_kind_sel,
  output logic [1:0]       pump_current_range,
  output logic             xtal_osc_off,
  output logic             pump_range_32ua
);
  logic [3:0]  src_reg;
  logic [11:0] rdiv_modulus_reg;
  logic [14:0] loop_div_modulus_reg;
  logic [5:0]  post_reg;
  logic [9:0]  mode_reg;
  logic [31:0] prdata_reg;
  logic        ref_meta_reg;
  logic        ref_sync_reg;
  logic        ref_prev_reg;
  logic        ret_meta_reg;
  logic        ret_sync_reg;
  logic        ret_prev_reg;
  logic        ref_tick;
  logic        ret_tick;
  logic        rdiv_in;
  logic        rdiv_tick;
  logic        post_stage_one_code_tick;
  logic        post_stage_two_code_tick;
  logic        post_stage_three_code_tick;
  logic        loop_in;
  logic        loop_tick;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        rdiv_source_sel;
  logic        loop_div_source_sel;
  logic        pd_lhs_input_sel;
  logic        pd_rhs_input_sel;

  // Post stage code to modulus-minus-one: codes 0..3 give 0,1,2,3, so a stage divides by 1,2,3,4
  function automatic logic [2:0] pdc_stage_mod(input pdc_post_code_type code);
    pdc_stage_mod = {1'b0, code};
  endfunction

  assign addr_ok = (paddr == `PDC_OFF_SRC) || (paddr == `PDC_OFF_RDIV) || (paddr == `PDC_OFF_LDIV) ||
                   (paddr == `PDC_OFF_POST) || (paddr == `PDC_OFF_MODE) || (paddr == `PDC_OFF_STATUS);
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign rd_en   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = prdata_reg;

  // Configuration writes land at the access-phase edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_reg              <= `PDC_RST_SRC;
      rdiv_modulus_reg     <= `PDC_RST_RDIV;
      loop_div_modulus_reg <= `PDC_RST_LDIV;
      post_reg             <= `PDC_RST_POST;
      mode_reg             <= `PDC_RST_MODE;
    end else if (wr_en) begin
      unique case (paddr)
        `PDC_OFF_SRC:  src_reg              <= pwdata[3:0];
        `PDC_OFF_RDIV: rdiv_modulus_reg     <= pwdata[11:0];
        `PDC_OFF_LDIV: loop_div_modulus_reg <= pwdata[14:0];
        `PDC_OFF_POST: post_reg             <= pwdata[5:0];
        `PDC_OFF_MODE: mode_reg             <= pwdata[9:0];
        default:       mode_reg             <= mode_reg;
      endcase
    end
  end

  // Read data registered in the setup cycle, valid in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (paddr)
        `PDC_OFF_SRC:    prdata_reg <= {28'h0, src_reg};
        `PDC_OFF_RDIV:   prdata_reg <= {20'h0, rdiv_modulus_reg};
        `PDC_OFF_LDIV:   prdata_reg <= {17'h0, loop_div_modulus_reg};
        `PDC_OFF_POST:   prdata_reg <= {26'h0, post_reg};
        `PDC_OFF_MODE:   prdata_reg <= {22'h0, mode_reg};
        `PDC_OFF_STATUS: prdata_reg <= {28'h0, pump_range_32ua, xtal_osc_off, pd_rhs_out, pd_lhs_out};
        default:         prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Pin inputs pass two flops, then a rising-edge detect on the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_meta_reg <= 1'b0;
      ref_sync_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
      ret_meta_reg <= 1'b0;
      ret_sync_reg <= 1'b0;
      ret_prev_reg <= 1'b0;
    end else begin
      ref_meta_reg <= ref_pin;
      ref_sync_reg <= ref_meta_reg;
      ref_prev_reg <= ref_sync_reg;
      ret_meta_reg <= return_clock_pin;
      ret_sync_reg <= ret_meta_reg;
      ret_prev_reg <= ret_sync_reg;
    end
  end

  assign ref_tick = ref_sync_reg && !ref_prev_reg;
  assign ret_tick = ret_sync_reg && !ret_prev_reg;

  assign rdiv_source_sel     = src_reg[`PDC_SRC_RDIV_BIT];
  assign loop_div_source_sel = src_reg[`PDC_SRC_LOOP_BIT];
  assign pd_lhs_input_sel    = src_reg[`PDC_SRC_PDL_BIT];
  assign pd_rhs_input_sel    = src_reg[`PDC_SRC_PDR_BIT];

  assign rdiv_in = rdiv_source_sel ? ref_tick : xtal_tick;

  pdc_divider #(.WIDTH(12)) u_rdiv (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (rdiv_in),
    .modulus  (rdiv_modulus_reg),
    .tick_out (rdiv_tick)
  );

  // Three cascaded post stages give the product of their moduli
  pdc_divider #(.WIDTH(3)) u_post_stage_one_code (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (vco_tick),
    .modulus  (pdc_stage_mod(post_reg[1:0])),
    .tick_out (post_stage_one_code_tick)
  );

  pdc_divider #(.WIDTH(3)) u_post_stage_two_code (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (post_stage_one_code_tick),
    .modulus  (pdc_stage_mod(post_reg[3:2])),
    .tick_out (post_stage_two_code_tick)
  );

  pdc_divider #(.WIDTH(3)) u_post_stage_three_code (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (post_stage_two_code_tick),
    .modulus  (pdc_stage_mod(post_reg[5:4])),
    .tick_out (post_stage_three_code_tick)
  );

  assign clk_out_tick = post_stage_three_code_tick;
  assign loop_in = loop_div_source_sel ? vco_tick : post_stage_three_code_tick;

  pdc_divider #(.WIDTH(15)) u_ldiv (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (loop_in),
    .modulus  (loop_div_modulus_reg),
    .tick_out (loop_tick)
  );

  assign pd_lhs_out = pd_lhs_input_sel ? ref_tick : rdiv_tick;
  assign pd_rhs_out = pd_rhs_input_sel ? ret_tick : loop_tick;

  assign outboard_filter_sel = mode_reg[`PDC_MODE_FILT_BIT];
  assign xtal_fine_tune_en   = mode_reg[`PDC_MODE_FINE_BIT];
  assign xtal_detector_off   = mode_reg[`PDC_MODE_DETO_BIT];
  assign osc_range_sel       = mode_reg[`PDC_MODE_RNG_BIT];
  assign oscillator_kind_sel = mode_reg[`PDC_MODE_KIND_BIT];
  assign xtal_ratio_code     = mode_reg[`PDC_MODE_XR_LSB +: 3];
  assign pump_current_range  = mode_reg[`PDC_MODE_PUMP_LSB +: 2];
  assign xtal_osc_off        = (xtal_ratio_code == `PDC_XTAL_OFF_CODE);
  assign pump_range_32ua     = (pump_current_range == `PDC_PUMP_32UA);
endmodule
`default_nettype wire

/* pdc_src_model.sv */
// Crystal, oscillator and pin source model
`timescale 1ns/1ps
`default_nettype none
module pdc_src_model (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      xtal_tick,
  output logic      vco_tick,
  output logic      ref_pin,
  output logic      return_clock_pin
);
  logic [3:0] cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_reg <= 4'h0;
    else cnt_reg <= cnt_reg + 4'h1;
  end
  assign xtal_tick = cnt_reg[0];
  assign vco_tick = 1'b1;
  assign ref_pin = cnt_reg[2];
  assign return_clock_pin = cnt_reg[3];
endmodule
`default_nettype wire

/* pdc_path_assertions.sv */
// Port assertions for the divider path
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defines.svh"
module pdc_path_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        vco_tick,
  input wire logic        clk_out_tick,
  input wire logic        outboard_filter_sel,
  input wire logic        osc_range_sel,
  input wire logic [2:0]  xtal_ratio_code,
  input wire logic        xtal_osc_off,
  input wire logic [1:0]  pump_current_range,
  input wire logic        pump_range_32ua
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mode_wr;
  assign mode_wr = psel && penable && pwrite && paddr == `PDC_OFF_MODE;
  chk_ready_high: assert property (pready) else $error("bad ready");
  chk_err_map: assert property (psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > `PDC_OFF_STATUS))
    else $error("bad pslverr");
  chk_filter_wr: assert property (mode_wr |=> outboard_filter_sel == $past(pwdata[0])) else $error("bad filter");
  chk_range_wr: assert property (mode_wr |-> ##1 osc_range_sel == $past(pwdata[3])) else $error("bad range");
  chk_mode_hold: assert property (!mode_wr |=> $stable(xtal_ratio_code) && $stable(pump_current_range))
    else $error("mode moved");
  chk_osc_off: assert property (xtal_osc_off == (xtal_ratio_code == `PDC_XTAL_OFF_CODE)) else $error("bad off");
  chk_pump_32: assert property (pump_range_32ua == (pump_current_range == `PDC_PUMP_32UA)) else $error("bad pump");
  chk_post_src: assert property (clk_out_tick |-> vco_tick) else $error("bad tick");
endmodule
bind pdc_path pdc_path_assertions pdc_path_assertions_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .vco_tick, .clk_out_tick, .outboard_filter_sel, .osc_range_sel, .xtal_ratio_code,
  .xtal_osc_off, .pump_current_range, .pump_range_32ua);
`default_nettype wire

/* pdc_path_tb_top.sv */
// Self-checking bench for the divider path
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defines.svh"
module pdc_path_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, xtal_tick, ref_pin, vco_tick, return_clock_pin;
  logic pd_lhs_out, pd_rhs_out, clk_out_tick, xtal_osc_off, pump_range_32ua, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  wire [9:0] mode_pins;
  int fails, total_checks, nl, nr, nc;
  pdc_path pdc_path_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .xtal_tick, .ref_pin, .vco_tick, .return_clock_pin, .pd_lhs_out, .pd_rhs_out, .clk_out_tick,
    .outboard_filter_sel(mode_pins[0]), .xtal_fine_tune_en(mode_pins[1]), .xtal_detector_off(mode_pins[2]),
    .osc_range_sel(mode_pins[3]), .oscillator_kind_sel(mode_pins[4]), .xtal_ratio_code(mode_pins[7:5]),
    .pump_current_range(mode_pins[9:8]), .xtal_osc_off, .pump_range_32ua);
  pdc_src_model pdc_src_model_i (.pclk, .presetn, .xtal_tick, .vco_tick, .ref_pin, .return_clock_pin);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic end_sim;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) fails++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic test_regs;
    apb(1'b0, `PDC_OFF_SRC, 32'h0);
    check(rdat, {28'h0, `PDC_RST_SRC});
    apb(1'b1, 12'h020, 32'hffffffff);
    check(rerr, 1'b1);
    apb(1'b1, `PDC_OFF_RDIV, 32'hfffff003);
    apb(1'b0, `PDC_OFF_RDIV, 32'h0);
    check(rdat, 32'h00000003);
    apb(1'b1, `PDC_OFF_RDIV, 32'h0);
    $display("register test done");
  endtask
  task automatic test_mode;
    logic [9:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {i[1:0], i[2:0], (i[0] ? 5'h15 : 5'h0a)};
      apb(1'b1, `PDC_OFF_MODE, {22'h0, v});
      @(negedge pclk);
      check(mode_pins, v);
      check({xtal_osc_off, pump_range_32ua}, {i == 7, i[1:0] == 2'h3});
    end
    $display("mode test done");
  endtask
  task automatic cfg(input logic [3:0] s, input logic [5:0] p, input logic [31:0] m, input int el, er, ec);
    apb(1'b1, `PDC_OFF_SRC, {28'h0, s});
    apb(1'b1, `PDC_OFF_RDIV, m);
    apb(1'b1, `PDC_OFF_LDIV, m);
    apb(1'b1, `PDC_OFF_POST, {26'h0, p});
    repeat (64) @(posedge pclk);
    {nl, nr, nc} = '0;
    repeat (96) begin
      @(negedge pclk);
      nl += pd_lhs_out;
      nr += pd_rhs_out;
      nc += clk_out_tick;
    end
    check(nl, el);
    check(nr, er);
    check(nc, ec);
  endtask
  task automatic test_div;
    cfg(4'h2, 6'h09, 3, 12, 24, 16);
    cfg(4'h1, 6'h01, 1, 6, 24, 48);
    cfg(4'hc, 6'h39, 1, 12, 6, 4);
    $display("divider test done");
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    test_regs;
    test_mode;
    test_div;
    end_sim;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    end_sim;
  end
endmodule
`default_nettype wire
